// ==== rrsr_ctl.sv ====
// memory controller end: refresh sequencing, rate changes, self refresh
`timescale 1ns/1ps
// Notes on behaviour
// - each refresh waits its own rate's cycle time
// - rate change needs whole pairs or quads
// - normal refresh between high rates needs multiples
// - same-rate fixed/otf switch is no change
// - temperature refresh only with fixed normal mode
// - device takes self refresh entry any count
// - odd double count owes extra refreshes
// - quad count not a multiple of four owes extras
// - entry: select, row, column low, cke falls
// - enter self refresh only when idle
// - cke held low during self refresh
// - termination and dll off in self refresh
// - reference bit picks write wait after exit
// - device refreshes internally, gates its clock
// - stay in self refresh minimum time
// - exit with cke rise and deselect; wait
// - calibration and some mode writes after fast
// - reads and writes wait dll lock time
// - deselect throughout exit, termination off
// - refresh needed before self refresh reentry
// - latency mode adds to exit delays
// - abort bit shortens exit wait
// - mode field and bank bit select rate
module rrsr_ctl (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // command bus
   rrsr_if.ctl BUS
);
   import rrsr_pkg::*;
   rrsr_state_type state_ff, nxt_state;
   logic [7:0] cfg_ff;
   logic [2:0] mode_ff;
   logic [1:0] step_ff;
   logic [CNT_W-1:0] busy_ff, sr_cnt_ff, exit_cnt_ff;
   logic [7:0] hi_cnt_ff;
   logic [2:0] owed_ff;
   logic ref_done_ff, exited_ff;
   logic [3:0] err_ff;
   logic cmd_wr;
   logic [2:0] cmd;
   logic hi_whole, busy, ok_ref_n, ok_ref_f, ok_mrs, ok_sre, ok_srx, refused;
   logic [CNT_W-1:0] xs_cyc;
   logic [1:0] cur_rate, cfg_rate;

   assign cmd_wr = REG_WR && (REG_ADDR == REG_CMD);
   assign cmd = REG_WDATA[2:0];
   assign busy = (busy_ff != '0);
   assign cur_rate = rate_of(mode_ff);
   assign cfg_rate = rate_of(cfg_ff[2:0]);
   // whole pairs for double rate, whole quads for quad rate
   assign hi_whole = (cur_rate == 2'h1) ? !hi_cnt_ff[0] :
                     (cur_rate == 2'h2) ? (hi_cnt_ff[1:0] == 2'h0) : 1'b1;
   // legality of each order
   assign ok_ref_n = (state_ff == RRSR_IDLE) && !busy && (!mode_ff[2] || hi_whole || owed_ff != '0) &&
                     (cur_rate == 2'h0 || mode_ff[2]);
   assign ok_ref_f = (state_ff == RRSR_IDLE) && !busy && (cur_rate != 2'h0);
   assign ok_mrs = (state_ff == RRSR_IDLE) && !busy && (cfg_rate == cur_rate || hi_whole)
                   && !(cfg_ff[3] && cfg_ff[2:0] != MODE_FIX1);
   assign ok_sre = (state_ff == RRSR_IDLE) && !busy && (!exited_ff || ref_done_ff);
   assign ok_srx = (state_ff == RRSR_SELF) && (sr_cnt_ff >= CNT_W'(TCKESR_CYC)) &&
                   (sr_cnt_ff >= CNT_W'(SR_IDLE_CYC));
   assign refused = cmd_wr && !((cmd == CMD_REF_NORM && ok_ref_n) || (cmd == CMD_REF_FAST && ok_ref_f) ||
                    (cmd == CMD_MRS && ok_mrs) || (cmd == CMD_SRE && ok_sre) || (cmd == CMD_SRX && ok_srx));
   // exit wait, abort-shortened, plus latency mode
   assign xs_cyc = (cfg_ff[4] ? CNT_W'(TXS_ABORT_CYC) : CNT_W'(TXS_CYC)) +
                   (cfg_ff[6] ? CNT_W'(TCAL_CYC) : CNT_W'(0));

   // configuration register
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) cfg_ff <= CFG_RESET;
      else if (REG_WR && REG_ADDR == REG_CFG) cfg_ff <= REG_WDATA[7:0];
   end

   // sequencer state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         RRSR_IDLE: begin
            if (cmd_wr && !refused && cmd == CMD_MRS) nxt_state = RRSR_MRS;
            else if (cmd_wr && !refused && cmd == CMD_SRE) nxt_state = RRSR_SELF;
         end
         RRSR_MRS: if (step_ff == 2'h2) nxt_state = RRSR_IDLE;
         RRSR_SELF: if (cmd_wr && !refused && cmd == CMD_SRX) nxt_state = RRSR_IDLE;
         default: nxt_state = RRSR_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) state_ff <= RRSR_IDLE;
      else state_ff <= nxt_state;
   end

   // mode-register write step: tcr register first, then rate, then reference
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) step_ff <= 2'h0;
      else if (state_ff == RRSR_MRS) step_ff <= step_ff + 2'h1;
      else step_ff <= 2'h0;
   end

   // rate mode the device now holds
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) mode_ff <= MODE_FIX1;
      else if (state_ff == RRSR_MRS && step_ff == 2'h1) mode_ff <= cfg_ff[2:0];
   end

   // command spacing timer
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) busy_ff <= '0;
      else if (cmd_wr && !refused && cmd == CMD_REF_NORM) busy_ff <= CNT_W'(TRFC1_CYC);
      else if (cmd_wr && !refused && cmd == CMD_REF_FAST)
         busy_ff <= (cur_rate == 2'h1) ? CNT_W'(TRFC2_CYC) : CNT_W'(TRFC4_CYC);
      else if (cmd_wr && !refused && cmd == CMD_SRX) busy_ff <= xs_cyc;
      else if (state_ff == RRSR_MRS) busy_ff <= CNT_W'(1);
      else if (busy) busy_ff <= busy_ff - CNT_W'(1);
   end

   // time in self refresh and time since exit
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         sr_cnt_ff <= '0;
         exit_cnt_ff <= CNT_W'(TXSDLL_CYC);
      end else begin
         if (state_ff != RRSR_SELF) sr_cnt_ff <= '0;
         else if (sr_cnt_ff != '1) sr_cnt_ff <= sr_cnt_ff + CNT_W'(1);
         if (cmd_wr && !refused && cmd == CMD_SRX) exit_cnt_ff <= '0;
         else if (exit_cnt_ff < CNT_W'(TXSDLL_CYC)) exit_cnt_ff <= exit_cnt_ff + CNT_W'(1);
      end
   end

   // high-rate count, owed extras and re-entry permission
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         hi_cnt_ff <= 8'h00;
         owed_ff <= 3'h0;
         ref_done_ff <= 1'b0;
         exited_ff <= 1'b0;
      end else if (cmd_wr && !refused) begin
         case (cmd)
            CMD_REF_NORM: begin
               hi_cnt_ff <= 8'h00;
               owed_ff <= 3'h0;
               ref_done_ff <= 1'b1;
            end
            CMD_REF_FAST: begin
               if (owed_ff != 3'h0) owed_ff <= owed_ff - 3'h1; // extras not counted
               else hi_cnt_ff <= hi_cnt_ff + 8'h01;
               ref_done_ff <= 1'b1;
            end
            CMD_MRS: if (cfg_rate != cur_rate) hi_cnt_ff <= 8'h00;
            CMD_SRX: begin
               hi_cnt_ff <= 8'h00;
               owed_ff <= hi_whole ? 3'h0 : ((cur_rate == 2'h1) ? 3'h2 : 3'h4);
               ref_done_ff <= 1'b0;
               exited_ff <= 1'b1;
            end
            default: hi_cnt_ff <= hi_cnt_ff;
         endcase
      end
   end

   // command bus drive; deselect whenever no command
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         BUS.cke <= 1'b0;
         {BUS.cs_n, BUS.act_n, BUS.ras_n, BUS.cas_n, BUS.we_n} <= 5'h1f;
         BUS.bg0 <= 1'b0;
         BUS.mr_sel <= 3'h0;
         BUS.addr <= 14'h0000;
         BUS.odt <= 1'b0;
      end else begin
         BUS.cke <= !(state_ff == RRSR_SELF || nxt_state == RRSR_SELF);
         BUS.odt <= cfg_ff[7] && state_ff != RRSR_SELF && nxt_state != RRSR_SELF &&
                    exit_cnt_ff >= CNT_W'(TXSDLL_CYC) && !(cmd_wr && cmd == CMD_SRX);
         {BUS.cs_n, BUS.act_n, BUS.ras_n, BUS.cas_n, BUS.we_n} <= 5'h1f;
         BUS.bg0 <= 1'b0;
         if (cmd_wr && !refused && (cmd == CMD_REF_NORM || cmd == CMD_REF_FAST || cmd == CMD_SRE)) begin
            {BUS.cs_n, BUS.act_n, BUS.ras_n, BUS.cas_n, BUS.we_n} <= 5'h09;
            BUS.bg0 <= (cmd == CMD_REF_FAST);
         end else if (state_ff == RRSR_MRS) begin
            {BUS.cs_n, BUS.act_n, BUS.ras_n, BUS.cas_n, BUS.we_n} <= 5'h08;
            BUS.addr <= 14'h0000;
            case (step_ff)
               2'h0: begin
                  BUS.mr_sel <= MR_SEL_4; // tcr goes off before rate moves
                  BUS.addr[MR4_TCR_BIT] <= cfg_ff[3];
                  BUS.addr[MR4_CAL_BIT] <= cfg_ff[6];
                  BUS.addr[MR4_ABORT_BIT] <= cfg_ff[4];
               end
               2'h1: begin
                  BUS.mr_sel <= MR_SEL_3;
                  BUS.addr[MR3_RATE_LSB+2:MR3_RATE_LSB] <= cfg_ff[2:0];
               end
               default: begin
                  BUS.mr_sel <= MR_SEL_6;
                  BUS.addr[MR6_VREF_BIT] <= cfg_ff[5];
               end
            endcase
         end
      end
   end

   // sticky refusal flags, set wins over write-one clear
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) err_ff <= 4'h0;
      else err_ff <= (err_ff & ~((REG_WR && REG_ADDR == REG_ERR) ? REG_WDATA[3:0] : 4'h0)) |
                     {refused && cmd == CMD_SRE, refused && cmd == CMD_MRS,
                      refused && (cmd == CMD_REF_NORM || cmd == CMD_REF_FAST), refused && cmd == CMD_SRX};
   end

   // read data, one cycle after the strobe
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) REG_RDATA <= 32'h0000_0000;
      else if (REG_RD) begin
         case (REG_ADDR)
            REG_CFG: REG_RDATA <= {24'h000000, cfg_ff};
            REG_STAT: REG_RDATA <= {8'h00, hi_cnt_ff, 1'b0, owed_ff, 1'b0, mode_ff,
                                    exit_cnt_ff >= CNT_W'(TXSDLL_CYC),
                                    exit_cnt_ff >= (cfg_ff[5] ? CNT_W'(TXS_CYC) : CNT_W'(TXSDLL_CYC)),
                                    exit_cnt_ff >= CNT_W'(TXS_FAST_CYC) + (cfg_ff[6] ? CNT_W'(TCAL_CYC)
                                                                          : CNT_W'(0)),
                                    ref_done_ff, busy, state_ff, 1'b0};
            REG_ERR: REG_RDATA <= {28'h0000000, err_ff};
            default: REG_RDATA <= 32'h0000_0000;
         endcase
      end else REG_RDATA <= 32'h0000_0000;
   end
endmodule

// ==== rrsr_pkg.sv ====
// shared constants and types for refresh-rate and self refresh control
package rrsr_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CNT_W = 10;

   // least time in ns to whole clock cycles, never under one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // refresh rate mode field codes (mode register 3, bits 8:6)
   localparam logic [2:0] MODE_FIX1 = 3'h0;
   localparam logic [2:0] MODE_FIX2 = 3'h1;
   localparam logic [2:0] MODE_FIX4 = 3'h2;
   localparam logic [2:0] MODE_OTF12 = 3'h5;
   localparam logic [2:0] MODE_OTF14 = 3'h6;
   localparam int MR3_RATE_LSB = 6;
   localparam int MR4_TCR_BIT = 3;
   localparam int MR4_CAL_BIT = 6;
   localparam int MR4_ABORT_BIT = 9;
   localparam int MR6_VREF_BIT = 7;
   localparam logic [2:0] MR_SEL_3 = 3'h3;
   localparam logic [2:0] MR_SEL_4 = 3'h4;
   localparam logic [2:0] MR_SEL_6 = 3'h6;

   // timing in ns and derived clock counts
   localparam int TRFC1_NS = 350;
   localparam int TRFC2_NS = 260;
   localparam int TRFC4_NS = 160;
   localparam int TXS_EXTRA_NS = 10;
   localparam int TXS_ABORT_NS = 170;
   localparam int TRFC1_CYC = ns_to_cyc(TRFC1_NS);
   localparam int TRFC2_CYC = ns_to_cyc(TRFC2_NS);
   localparam int TRFC4_CYC = ns_to_cyc(TRFC4_NS);
   localparam int TXS_CYC = ns_to_cyc(TRFC1_NS + TXS_EXTRA_NS);
   localparam int TXS_FAST_CYC = ns_to_cyc(TRFC4_NS + TXS_EXTRA_NS);
   localparam int TXS_ABORT_CYC = ns_to_cyc(TXS_ABORT_NS);
   localparam int TCAL_CYC = 3;
   localparam int TCKSRE_CYC = 8;
   localparam int TCKSRX_CYC = 8;
   localparam int TXSDLL_CYC = 512;
   localparam int TCKESR_CYC = 2;
   localparam int SR_IDLE_CYC = TCKSRE_CYC + TCKSRX_CYC;

   // controller register offsets and command codes
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_ERR = 4'hc;
   localparam logic [2:0] CMD_REF_NORM = 3'h1;
   localparam logic [2:0] CMD_REF_FAST = 3'h2;
   localparam logic [2:0] CMD_MRS = 3'h3;
   localparam logic [2:0] CMD_SRE = 3'h4;
   localparam logic [2:0] CMD_SRX = 3'h5;
   localparam logic [7:0] CFG_RESET = 8'h00;

   typedef enum logic [1:0] {
      RRSR_IDLE = 2'b00,
      RRSR_MRS = 2'b01,
      RRSR_SELF = 2'b10
   } rrsr_state_type;

   // 0 normal, 1 double, 2 quad
   function automatic logic [1:0] rate_of(input logic [2:0] mode);
      case (mode)
         MODE_FIX2, MODE_OTF12: rate_of = 2'h1;
         MODE_FIX4, MODE_OTF14: rate_of = 2'h2;
         default: rate_of = 2'h0;
      endcase
   endfunction
endpackage

// ==== rrsr_if.sv ====
// command bus between memory controller and memory device
`timescale 1ns/1ps
interface rrsr_if;
   logic cke;
   logic cs_n;
   logic act_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic bg0;
   logic [2:0] mr_sel;
   logic [13:0] addr;
   logic odt;
   modport ctl (output cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, addr, odt);
   modport dev (input cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, addr, odt);
endinterface

// ==== rrsr_dev.sv ====
// memory device end: refresh rate modes and self refresh behaviour
`timescale 1ns/1ps
module rrsr_dev #(
   parameter int SR_REF_PERIOD = 156
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // command bus
   rrsr_if.dev BUS,
   // status
   output logic SR_ACTIVE,
   output logic CLK_GATED,
   output logic TERM_ON,
   output logic DLL_ON,
   output logic DLL_RESET,
   output logic REF_BUSY,
   output logic [7:0] REF_COUNT
);
   import rrsr_pkg::*;
   logic cke_prev_ff, sr_ff, busy_any;
   logic [2:0] mode_ff;
   logic abort_ff;
   logic [CNT_W-1:0] busy_ff, tmr_ff, lock_ff;
   logic is_ref, is_sre, is_mrs, is_srx;
   logic [1:0] ref_rate;
   logic [CNT_W-1:0] nxt_trfc;

   // command decode, only exit decoded while in self refresh
   assign is_ref = !sr_ff && cke_prev_ff && BUS.cke && !BUS.cs_n && BUS.act_n && !BUS.ras_n && !BUS.cas_n
                   && BUS.we_n;
   assign is_sre = !sr_ff && cke_prev_ff && !BUS.cke && !BUS.cs_n && BUS.act_n && !BUS.ras_n && !BUS.cas_n
                   && BUS.we_n;
   assign is_mrs = !sr_ff && cke_prev_ff && BUS.cke && !BUS.cs_n && BUS.act_n && !BUS.ras_n && !BUS.cas_n
                   && !BUS.we_n;
   assign is_srx = sr_ff && BUS.cke && BUS.cs_n;
   assign busy_any = (busy_ff != '0);
   // per-command rate: bank group bit in on-the-fly modes
   assign ref_rate = (mode_ff[2] && !BUS.bg0) ? 2'h0 : rate_of(mode_ff);
   assign nxt_trfc = (ref_rate == 2'h1) ? CNT_W'(TRFC2_CYC) :
                     (ref_rate == 2'h2) ? CNT_W'(TRFC4_CYC) : CNT_W'(TRFC1_CYC);

   // clock enable history
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) cke_prev_ff <= 1'b0;
      else cke_prev_ff <= BUS.cke;
   end

   // mode registers
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         mode_ff <= MODE_FIX1;
         abort_ff <= 1'b0;
      end else if (is_mrs && BUS.mr_sel == MR_SEL_3) begin
         mode_ff <= BUS.addr[MR3_RATE_LSB+2:MR3_RATE_LSB];
      end else if (is_mrs && BUS.mr_sel == MR_SEL_4) begin
         abort_ff <= BUS.addr[MR4_ABORT_BIT];
      end
   end

   // self refresh state
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) sr_ff <= 1'b0;
      else if (is_sre) sr_ff <= 1'b1;
      else if (is_srx) sr_ff <= 1'b0;
   end

   // refresh cycle timer; internal refreshes while in self refresh
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         busy_ff <= '0;
         tmr_ff <= '0;
         REF_COUNT <= 8'h00;
      end else if (is_srx && abort_ff && busy_any) begin
         busy_ff <= '0; // abort without advancing the counter
      end else if (is_ref) begin
         busy_ff <= nxt_trfc;
      end else if (is_sre) begin
         busy_ff <= CNT_W'(TRFC1_CYC); // first internal refresh at entry
         tmr_ff <= CNT_W'(SR_REF_PERIOD);
      end else begin
         if (busy_ff == CNT_W'(1)) REF_COUNT <= REF_COUNT + 8'h01;
         if (busy_any) busy_ff <= busy_ff - CNT_W'(1);
         if (sr_ff && tmr_ff != '0) tmr_ff <= tmr_ff - CNT_W'(1);
         else if (sr_ff && !busy_any) begin
            busy_ff <= CNT_W'(TRFC1_CYC); // own timer
            tmr_ff <= CNT_W'(SR_REF_PERIOD);
         end
      end
   end

   // dll relock after exit
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) lock_ff <= '0;
      else if (is_srx) lock_ff <= CNT_W'(TXSDLL_CYC);
      else if (lock_ff != '0) lock_ff <= lock_ff - CNT_W'(1);
   end

   // registered status outputs
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         SR_ACTIVE <= 1'b0;
         CLK_GATED <= 1'b0;
         TERM_ON <= 1'b0;
         DLL_ON <= 1'b1;
         DLL_RESET <= 1'b0;
         REF_BUSY <= 1'b0;
      end else begin
         SR_ACTIVE <= sr_ff;
         CLK_GATED <= sr_ff;
         TERM_ON <= BUS.odt && !sr_ff && !is_sre;
         DLL_ON <= !sr_ff && (lock_ff == '0) && !is_srx;
         DLL_RESET <= is_srx;
         REF_BUSY <= busy_any;
      end
   end
endmodule

// ==== rrsr_monitor.sv ====
// assertions on the command bus between controller and device
`timescale 1ns/1ps
module rrsr_monitor (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // command bus
   input wire logic cke,
   input wire logic cs_n,
   input wire logic act_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bg0,
   input wire logic [2:0] mr_sel,
   input wire logic [13:0] addr,
   input wire logic odt
);
   import rrsr_pkg::*;
   logic ref_c, mrs_c, fast, cke_q, sr_q, ref_since_ff, tcr_ff;
   logic [2:0] mode_ff;
   logic [3:0] gap_ff, need_ff;
   logic [4:0] low_ff;
   logic [9:0] xs_ff;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // decoded commands
   assign ref_c = cke && !cs_n && act_n && !ras_n && !cas_n && we_n;
   assign mrs_c = !cs_n && act_n && !ras_n && !cas_n && !we_n;
   assign fast = mode_ff != MODE_FIX1 && (!mode_ff[2] || bg0);
   // bus history: mode, refresh spacing, self refresh and exit timers
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         cke_q <= 1'b0;
         sr_q <= 1'b0;
         ref_since_ff <= 1'b1;
         tcr_ff <= 1'b0;
         mode_ff <= 3'h0;
         gap_ff <= 4'hf;
         need_ff <= 4'h0;
         low_ff <= 5'h10;
         xs_ff <= 10'h3ff;
      end else begin
         cke_q <= cke;
         sr_q <= (cke_q && !cke) ? 1'b1 : (cke ? 1'b0 : sr_q);
         ref_since_ff <= ref_c ? 1'b1 : ((sr_q && cke) ? 1'b0 : ref_since_ff);
         if (mrs_c && mr_sel == MR_SEL_4) tcr_ff <= addr[MR4_TCR_BIT];
         if (mrs_c && mr_sel == MR_SEL_3) mode_ff <= addr[8:6];
         gap_ff <= ref_c ? 4'h1 : ((gap_ff == 4'hf) ? gap_ff : gap_ff + 4'h1);
         if (ref_c) need_ff <= !fast ? 4'(TRFC1_CYC) : (mode_ff[1] ? 4'(TRFC4_CYC) : 4'(TRFC2_CYC));
         low_ff <= cke ? 5'h0 : ((low_ff == 5'h10) ? low_ff : low_ff + 5'h1);
         xs_ff <= (sr_q && cke) ? 10'h1 : ((xs_ff == 10'h3ff) ? xs_ff : xs_ff + 10'h1);
      end
   end
   property p_sre_pins;
      $fell(cke) |-> !cs_n && !ras_n && !cas_n && we_n && act_n && !odt;
   endproperty
   a_sre_pins: assert property (p_sre_pins) else $error("entry pins wrong");
   property p_ref_one;
      ref_c |=> cs_n;
   endproperty
   a_ref_one: assert property (p_ref_one) else $error("refresh longer than one cycle");
   property p_sr_hold;
      $fell(cke) |=> (!cke) [*8];
   endproperty
   a_sr_hold: assert property (p_sr_hold) else $error("cke not held low");
   property p_sr_min;
      $rose(cke) |-> low_ff >= SR_IDLE_CYC;
   endproperty
   a_sr_min: assert property (p_sr_min) else $error("self refresh too short");
   property p_xs_desel;
      $rose(cke) |-> cs_n [*4];
   endproperty
   a_xs_desel: assert property (p_xs_desel) else $error("command during exit delay");
   property p_odt_sr;
      !cke |-> !odt;
   endproperty
   a_odt_sr: assert property (p_odt_sr) else $error("termination in self refresh");
   property p_odt_dll;
      odt |-> xs_ff >= TXSDLL_CYC - 2;
   endproperty
   a_odt_dll: assert property (p_odt_dll) else $error("termination before dll lock");
   property p_reentry;
      $fell(cke) |-> ref_since_ff;
   endproperty
   a_reentry: assert property (p_reentry) else $error("reentry without refresh");
   property p_ref_gap;
      !cs_n |-> gap_ff >= need_ff;
   endproperty
   a_ref_gap: assert property (p_ref_gap) else $error("refresh cycle time cut");
   property p_tcr;
      mrs_c && mr_sel == MR_SEL_3 |-> !(tcr_ff && addr[8:6] != MODE_FIX1);
   endproperty
   a_tcr: assert property (p_tcr) else $error("temperature refresh with fast mode");
   // main scenarios
   c_ref: cover property (ref_c);
   c_entry: cover property ($fell(cke));
   c_exit: cover property ($rose(cke) && sr_q);
   c_mode: cover property (mrs_c && mr_sel == MR_SEL_3);
endmodule

// ==== tb_refresh_rate_and_self_refresh.sv ====
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module tb_refresh_rate_and_self_refresh;
   import rrsr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, rv, dv;
   logic sr_active, clk_gated, term_on, dll_on, dll_reset, ref_busy, sr2, term2, seen;
   logic [7:0] ref_count;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int n, t0;
   rrsr_if rrsr_if_i ();
   rrsr_if rrsr_if_b_i ();
   rrsr_ctl rrsr_ctl_i (.CORE_CLK(core_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUS(rrsr_if_i));
   rrsr_dev #(.SR_REF_PERIOD(10)) rrsr_dev_i (.CORE_CLK(core_clk), .RST_B(rst_b), .BUS(rrsr_if_i),
      .SR_ACTIVE(sr_active), .CLK_GATED(clk_gated), .TERM_ON(term_on), .DLL_ON(dll_on),
      .DLL_RESET(dll_reset), .REF_BUSY(ref_busy), .REF_COUNT(ref_count));
   rrsr_dev #(.SR_REF_PERIOD(10)) rrsr_dev_b_i (.CORE_CLK(core_clk), .RST_B(rst_b), .BUS(rrsr_if_b_i),
      .SR_ACTIVE(sr2), .CLK_GATED(), .TERM_ON(term2), .DLL_ON(), .DLL_RESET(), .REF_BUSY(), .REF_COUNT());
   rrsr_monitor rrsr_monitor_i (.CORE_CLK(core_clk), .RST_B(rst_b), .cke(rrsr_if_i.cke),
      .cs_n(rrsr_if_i.cs_n), .act_n(rrsr_if_i.act_n), .ras_n(rrsr_if_i.ras_n), .cas_n(rrsr_if_i.cas_n),
      .we_n(rrsr_if_i.we_n), .bg0(rrsr_if_i.bg0), .mr_sel(rrsr_if_i.mr_sel), .addr(rrsr_if_i.addr),
      .odt(rrsr_if_i.odt));
   // device status packed for masked compares
   assign dv = {ref_count, 18'h0, ref_busy, dll_reset, dll_on, term_on, clk_gated, sr_active};
   // clock and hang guard
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // register port cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, rv);
      chk(rv & m, e);
   endtask
   task automatic dc(input logic [31:0] m, input logic [31:0] e);
      chk(dv & m, e);
   endtask
   task automatic ec(input logic [31:0] e);
      rc(REG_ERR, 32'hf, e);
      wr(REG_ERR, 32'hf);
   endtask
   task automatic cmd(input logic [2:0] c);
      wr(REG_CMD, {29'h0, c});
   endtask
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      n = 0;
      rv = ~v;
      while ((rv & m) !== v && n < 400) begin
         rd(REG_STAT, rv);
         n++;
      end
      if (n == 400) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, rv & m, v);
      end
   endtask
   task automatic cfg(input logic [7:0] x, input logic [2:0] md);
      wr(REG_CFG, {24'h0, x[7:3], md});
      cmd(CMD_MRS);
      poll(32'he, 32'h0);
   endtask
   task automatic at(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // second device pins: cke cs act ras cas we odt
   task automatic p2(input logic [6:0] v);
      @(posedge core_clk);
      {rrsr_if_b_i.cke, rrsr_if_b_i.cs_n, rrsr_if_b_i.act_n, rrsr_if_b_i.ras_n, rrsr_if_b_i.cas_n,
         rrsr_if_b_i.we_n, rrsr_if_b_i.odt} <= v;
   endtask
   initial begin
      {rrsr_if_b_i.cke, rrsr_if_b_i.cs_n, rrsr_if_b_i.act_n, rrsr_if_b_i.ras_n, rrsr_if_b_i.cas_n,
         rrsr_if_b_i.we_n, rrsr_if_b_i.odt} = 7'h7e;
      {rrsr_if_b_i.bg0, rrsr_if_b_i.mr_sel, rrsr_if_b_i.addr} = 18'h0;
      at(6);
      rst_b <= 1'b1;
      at(10);
      rc(REG_CFG, 32'hff, 32'h0);
      rc(4'h2, 32'hffffffff, 32'h0);
      rc(REG_STAT, 32'hef, 32'he0);
      dc(32'hff00003f, 32'h08);
      cmd(CMD_REF_NORM);
      poll(32'he, 32'h0);
      at(4);
      dc(32'hff000000, 32'h01000000);
      cmd(CMD_REF_FAST);
      ec(32'h2);
      $display("test normal refresh done");
      cfg(8'h0, MODE_FIX2);
      rc(REG_STAT, 32'h700, 32'h100);
      cmd(CMD_REF_FAST);
      poll(32'he, 32'h0);
      rc(REG_STAT, 32'hff0000, 32'h10000);
      cfg(8'h0, MODE_FIX1);
      ec(32'h4);
      cfg(8'h0, MODE_OTF12);
      ec(32'h0);
      rc(REG_STAT, 32'h700, 32'h500);
      cmd(CMD_REF_NORM);
      ec(32'h2);
      cmd(CMD_REF_FAST);
      poll(32'he, 32'h0);
      cmd(CMD_REF_NORM);
      poll(32'he, 32'h0);
      ec(32'h0);
      cfg(8'h08, MODE_OTF14);
      ec(32'h4);
      cfg(8'h0, MODE_OTF14);
      rc(REG_STAT, 32'h700, 32'h600);
      $display("test rate changes done");
      cmd(CMD_REF_FAST);
      poll(32'he, 32'h0);
      cmd(CMD_SRE);
      at(3);
      dc(32'h0f, 32'h03);
      cmd(CMD_SRX);
      ec(32'h1);
      seen = 1'b0;
      repeat (30) begin
         at(1);
         seen |= ref_busy;
      end
      chk({31'h0, seen}, 32'h1);
      cmd(CMD_SRX);
      at(2);
      dc(32'h18, 32'h10);
      at(1);
      dc(32'h19, 32'h00);
      rc(REG_STAT, 32'h7000, 32'h4000);
      poll(32'he, 32'h0);
      cmd(CMD_SRE);
      ec(32'h8);
      repeat (4) begin
         cmd(CMD_REF_FAST);
         poll(32'he, 32'h0);
      end
      rc(REG_STAT, 32'hff7010, 32'h10);
      poll(32'h80, 32'h80);
      at(4);
      dc(32'h08, 32'h08);
      rc(REG_STAT, 32'h40, 32'h40);
      $display("test quad self refresh done");
      cfg(8'hf0, MODE_FIX2);
      cmd(CMD_REF_FAST);
      poll(32'he, 32'h0);
      cmd(CMD_SRE);
      at(20);
      cmd(CMD_SRX);
      t0 = cyc;
      poll(32'h8, 32'h0);
      chk({31'h0, (cyc - t0) >= 7 && (cyc - t0) <= 10}, 32'h1);
      rc(REG_STAT, 32'h7000, 32'h2000);
      dc(32'h04, 32'h0);
      poll(32'h80, 32'h80);
      at(4);
      dc(32'h0c, 32'h0c);
      cmd(CMD_REF_NORM);
      ec(32'h2);
      repeat (2) begin
         cmd(CMD_REF_FAST);
         poll(32'he, 32'h0);
      end
      rc(REG_STAT, 32'h7000, 32'h0);
      ec(32'h0);
      $display("test abort exit done");
      p2(7'h7e);
      p2(7'h7e);
      p2(7'h10);
      p2(7'h7e);
      at(3);
      chk({31'h0, sr2}, 32'h0);
      p2(7'h12);
      p2(7'h01);
      at(3);
      chk({30'h0, sr2, term2}, 32'h2);
      p2(7'h7e);
      at(4);
      chk({31'h0, sr2}, 32'h0);
      $display("test device pins done");
      results();
   end
endmodule
